// >>> core/tlink_regs.svh
// register offsets, field positions, reset values and timing counts for the trigger link block
`ifndef TLINK_REGS_SVH
`define TLINK_REGS_SVH

`define TLINK_CLK_NS        100
`define TLINK_MERGE_NS      250
`define TLINK_OFF_CTRL      8'h00
`define TLINK_OFF_IN0       8'h04
`define TLINK_OFF_IN1       8'h08
`define TLINK_OFF_STAT      8'h0c
`define TLINK_OFF_EVT0      8'h10
`define TLINK_OFF_EVT1      8'h14
// control register fields
`define TLINK_CTRL_START    0
`define TLINK_CTRL_STOP     1
`define TLINK_CTRL_BPMODE   2
`define TLINK_CTRL_LINKED   3
// per input config fields
`define TLINK_IN_SRC_LSB    0
`define TLINK_IN_DST_LSB    3
`define TLINK_IN_WHP        5
`define TLINK_IN_PEAKMODE   6
`define TLINK_IN_ROI_EN     7
`define TLINK_IN_ERR_EN     8
`define TLINK_IN_BUSY_LSB   16
`define TLINK_IN_RESET      32'h0000_0000
// status fields
`define TLINK_ST_RUN        0
`define TLINK_ST_WAIT       1
`define TLINK_ST_REJ        2

`endif

// >>> core/tlink_pkg.sv
// types shared by the trigger link block
package tlink_pkg;
    typedef enum logic [2:0] {
        TLINK_SRC_SELF  = 3'b000,
        TLINK_SRC_OTHER = 3'b001,
        TLINK_SRC_OSCA  = 3'b010,
        TLINK_SRC_LINK  = 3'b011,
        TLINK_SRC_BP    = 3'b100
    } tlink_src_e;
    typedef enum logic [1:0] {
        TLINK_DST_NONE = 2'b00,
        TLINK_DST_BP   = 2'b01,
        TLINK_DST_LINK = 2'b10
    } tlink_dst_e;
    typedef enum logic [1:0] {
        TLINK_ST_IDLE = 2'b00,
        TLINK_ST_ARM  = 2'b01,
        TLINK_ST_RUN  = 2'b10
    } tlink_run_e;
    typedef struct packed {
        logic       err_en;
        logic       roi_en;
        logic       peak_mode;
        logic       send_whp;
        tlink_dst_e dst;
        tlink_src_e src;
    } tlink_cfg_s;
    typedef struct packed {
        logic self_station_trigger_terminal;
        logic peak_done;
        logic peak_in_roi;
        logic peak_err;
    } tlink_front_s;
endpackage

// >>> core/tlink_chan.sv
// one input channel: source select, busy window, event qualification
`timescale 1ns/10ps
`include "tlink_regs.svh"
module tlink_chan
    import tlink_pkg::*;
#(
    parameter int BUSY_W = 16
) (
    input  wire logic              clk_i,       // module clock
    input  wire logic              rst_i,       // sync reset
    input  wire tlink_cfg_s        cfg_i,       // channel setup
    input  wire logic [BUSY_W-1:0] busy_cyc_i,  // window plus processing, cycles
    input  wire logic              run_i,       // measurement running
    input  wire tlink_front_s      front_i,     // analog front-end events
    input  wire logic              oth_station_trigger_terminal_i,  // other input trigger
    input  wire logic              oth_whp_i,   // other input window hit
    input  wire logic              link_ev_i,   // link line event
    input  wire logic              bp_ev_i,     // backplane event
    output logic                   station_trigger_terminal_o,      // accepted trigger pulse
    output logic                   whp_o,       // window hit pulse
    output logic                   valid_o,     // valid event kept
    output logic                   busy_o       // peak detection in progress
);
    logic [BUSY_W-1:0] cnt_q;
    logic              sel_w;
    logic              take_w;
    logic              keep_w;

    // trigger source multiplexer
    assign sel_w = (cfg_i.src == TLINK_SRC_SELF)  ? front_i.self_station_trigger_terminal :
                   (cfg_i.src == TLINK_SRC_OTHER) ? oth_station_trigger_terminal_i :
                   (cfg_i.src == TLINK_SRC_OSCA)  ? oth_whp_i :
                   (cfg_i.src == TLINK_SRC_LINK)  ? link_ev_i :
                   (cfg_i.src == TLINK_SRC_BP)    ? bp_ev_i : 1'b0;
    // a trigger while busy is dropped, not queued
    assign take_w = run_i && sel_w && !busy_o;
    // discard out-of-region or erroneous peaks
    assign keep_w = front_i.peak_done && busy_o && (!cfg_i.roi_en || front_i.peak_in_roi)
                    && !(cfg_i.err_en && front_i.peak_err);

    // busy window counter
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= '0;
        end else if (take_w) begin
            cnt_q <= busy_cyc_i;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - BUSY_W'(1);
        end
    end
    assign busy_o = (cnt_q != '0);

    // registered event pulses
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            station_trigger_terminal_o  <= 1'b0;
            whp_o   <= 1'b0;
            valid_o <= 1'b0;
        end else begin
            station_trigger_terminal_o  <= take_w;
            whp_o   <= keep_w && cfg_i.peak_mode;
            valid_o <= keep_w;
        end
    end

    chk_busy_drop : assert property (@(posedge clk_i) disable iff (rst_i)
        busy_o && sel_w |=> !station_trigger_terminal_o) else $error("trigger accepted while busy");
    chk_whp_peak : assert property (@(posedge clk_i) disable iff (rst_i)
        whp_o |-> $past(cfg_i.peak_mode) && $past(front_i.peak_done)) else $error("window hit without peak");
    chk_roi_discard : assert property (@(posedge clk_i) disable iff (rst_i)
        cfg_i.roi_en && !front_i.peak_in_roi |=> !valid_o) else $error("out of region kept");
endmodule

// >>> core/tlink_top.sv
// trigger routing and measurement start control with a wishbone register slave
`timescale 1ns/10ps
`include "tlink_regs.svh"
// Contract
// - The received link trigger is the OR of all drivers, and pulses closer than 250 ns may merge.
// - With region or error check enabled, out-of-region or failed peaks are discarded despite a trigger.
// - A slave still busy with a previous peak may miss a linked trigger, which is not queued.
// - In normal mode measurement starts directly on the start command.
// - In backplane-start mode a start command waits for a backplane pulse before measuring.
// - All armed modules seeing one backplane pulse start together on it.
// - Selecting the backplane line as trigger source is rejected while in backplane-start mode.
// - Start mode is one shared setting per linked group, own setting when unlinked.
// - Each input can drive its trigger or window hit pulse onto the link line, and any input may use it.
// - An input's trigger output is suppressed while its previous event is still measured.
// - A window hit pulse comes only in peak mode, inside the region, and never for flagged errors; the code checks region and error only with roi_en and err_en set.
// - Each input's output destination is none, backplane line or link line.
module tlink_top
    import tlink_pkg::*;
#(
    parameter int BUSY_W = 16,
    parameter int MERGE_CYC = (`TLINK_MERGE_NS + `TLINK_CLK_NS - 1) / `TLINK_CLK_NS
) (
    input  wire logic        clk_i,         // 10 MHz module clock
    input  wire logic        rst_i,         // sync reset, active high
    input  wire logic [7:0]  adr_i,         // wishbone byte address
    input  wire logic [31:0] dat_i,         // wishbone write data
    input  wire logic [3:0]  sel_i,         // wishbone byte selects
    input  wire logic        we_i,          // wishbone write
    input  wire logic        cyc_i,         // wishbone cycle
    input  wire logic        stb_i,         // wishbone strobe
    output logic [31:0]      dat_o,         // wishbone read data
    output logic             ack_o,         // wishbone ack
    output logic             err_o,         // wishbone error, unmapped
    input  wire logic [1:0]  self_station_trigger_terminal_i,   // self trigger per input
    input  wire logic [1:0]  peak_done_i,   // peak detection finished
    input  wire logic [1:0]  peak_roi_i,    // peak lies in region
    input  wire logic [1:0]  peak_err_i,    // peak failed error check
    input  wire logic        link_line_i,   // wired-or link line level
    input  wire logic        bp_line_i,     // backplane trigger line level
    input  wire logic        grp_bpmode_i,  // start mode shared by link group
    output logic             link_line_o,   // drive link line
    output logic             link_line_oe_o,// link line enable
    output logic             bp_line_o,     // drive backplane line
    output logic             bp_line_oe_o,  // backplane line enable
    output logic             run_o,         // measurement running
    output logic [1:0]       valid_o        // valid event per input
);
    tlink_cfg_s        cfg_q [2];
    logic [BUSY_W-1:0] busy_q [2];
    logic              bpmode_q, linked_q, rej_q;
    tlink_run_e        st_q;
    logic [1:0]        link_s_q, bp_s_q;
    logic              link_d_q, bp_d_q;
    logic [3:0]        lhold_q, bhold_q;
    logic [1:0]        station_trigger_terminal_w, whp_w, busy_w, valid_w;
    logic              link_ev_w, bp_ev_w, bpmode_w, run_w;
    logic              wr_w, rd_hit_w, map_w;
    logic [31:0]       rdat_w;
    logic [1:0]        link_drv_w, bp_drv_w;
    logic              start_w, stop_w;
    tlink_cfg_s        wcfg_w;
    logic [31:0]       evt_q [2];

    // flag illegal source choice
    function automatic logic src_bad(input tlink_cfg_s c, input logic bpm);
        src_bad = bpm && (c.src == TLINK_SRC_BP);
    endfunction

    // synchronise and edge-detect incoming lines; first stage feeds only the second
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            link_s_q <= 2'b00;
            bp_s_q   <= 2'b00;
            link_d_q <= 1'b0;
            bp_d_q   <= 1'b0;
        end else begin
            link_s_q <= {link_s_q[0], link_line_i};
            bp_s_q   <= {bp_s_q[0], bp_line_i};
            link_d_q <= link_s_q[1];
            bp_d_q   <= bp_s_q[1];
        end
    end
    // wired-or line: any driver raises it, overlapping pulses give one edge
    assign link_ev_w = link_s_q[1] && !link_d_q;
    assign bp_ev_w   = bp_s_q[1] && !bp_d_q;

    // shared group mode when linked, own setting otherwise
    assign bpmode_w = linked_q ? grp_bpmode_i : bpmode_q;
    assign run_w    = (st_q == TLINK_ST_RUN);

    // bus decode
    assign wr_w  = cyc_i && stb_i && we_i && !ack_o && !err_o;
    assign map_w = (adr_i == `TLINK_OFF_CTRL) || (adr_i == `TLINK_OFF_IN0) || (adr_i == `TLINK_OFF_IN1)
                   || (adr_i == `TLINK_OFF_STAT) || (adr_i == `TLINK_OFF_EVT0) || (adr_i == `TLINK_OFF_EVT1);
    assign rd_hit_w = cyc_i && stb_i && !ack_o && !err_o;
    assign start_w  = wr_w && sel_i[0] && (adr_i == `TLINK_OFF_CTRL) && dat_i[`TLINK_CTRL_START];
    assign stop_w   = wr_w && sel_i[0] && (adr_i == `TLINK_OFF_CTRL) && dat_i[`TLINK_CTRL_STOP];
    assign wcfg_w   = tlink_cfg_s'(dat_i[8:0]);

    // read mux
    always_comb begin
        rdat_w = 32'h0000_0000;
        if (adr_i == `TLINK_OFF_CTRL) begin
            rdat_w[`TLINK_CTRL_BPMODE] = bpmode_q;
            rdat_w[`TLINK_CTRL_LINKED] = linked_q;
        end else if (adr_i == `TLINK_OFF_IN0) begin
            rdat_w[8:0] = cfg_q[0];
            rdat_w[`TLINK_IN_BUSY_LSB +: BUSY_W] = busy_q[0];
        end else if (adr_i == `TLINK_OFF_IN1) begin
            rdat_w[8:0] = cfg_q[1];
            rdat_w[`TLINK_IN_BUSY_LSB +: BUSY_W] = busy_q[1];
        end else if (adr_i == `TLINK_OFF_STAT) begin
            rdat_w[`TLINK_ST_RUN]  = run_w;
            rdat_w[`TLINK_ST_WAIT] = (st_q == TLINK_ST_ARM);
            rdat_w[`TLINK_ST_REJ]  = rej_q;
            rdat_w[5:4]            = busy_w;
        end else if (adr_i == `TLINK_OFF_EVT0) begin
            rdat_w = evt_q[0];
        end else if (adr_i == `TLINK_OFF_EVT1) begin
            rdat_w = evt_q[1];
        end
    end

    // bus answer, one cycle after the request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            err_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= rd_hit_w && map_w;
            err_o <= rd_hit_w && !map_w;
            dat_o <= (rd_hit_w && map_w && !we_i) ? rdat_w : 32'h0000_0000;
        end
    end

    // configuration registers; backplane source refused in backplane-start mode
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bpmode_q <= 1'b0;
            linked_q <= 1'b0;
            rej_q    <= 1'b0;
            for (int i = 0; i < 2; i++) begin
                cfg_q[i]  <= tlink_cfg_s'(9'h000);
                busy_q[i] <= '0;
            end
        end else if (wr_w && sel_i[0]) begin
            if (adr_i == `TLINK_OFF_CTRL) begin
                bpmode_q <= dat_i[`TLINK_CTRL_BPMODE];
                linked_q <= dat_i[`TLINK_CTRL_LINKED];
            end else if (adr_i == `TLINK_OFF_IN0 || adr_i == `TLINK_OFF_IN1) begin
                if (src_bad(wcfg_w, bpmode_w)) begin
                    rej_q <= 1'b1;
                end else begin
                    rej_q <= 1'b0;
                    cfg_q[adr_i[3]] <= wcfg_w;
                    if (sel_i[2] && sel_i[3]) begin
                        busy_q[adr_i[3]] <= dat_i[`TLINK_IN_BUSY_LSB +: BUSY_W];
                    end
                end
            end
        end
    end

    // start state machine
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= TLINK_ST_IDLE;
        end else begin
            case (st_q)
                TLINK_ST_IDLE: begin
                    if (start_w) begin
                        st_q <= bpmode_w ? TLINK_ST_ARM : TLINK_ST_RUN;
                    end
                end
                TLINK_ST_ARM: begin
                    if (stop_w) begin
                        st_q <= TLINK_ST_IDLE;
                    end else if (bp_ev_w) begin
                        st_q <= TLINK_ST_RUN;
                    end
                end
                TLINK_ST_RUN: begin
                    if (stop_w) begin
                        st_q <= TLINK_ST_IDLE;
                    end
                end
                default: st_q <= TLINK_ST_IDLE;
            endcase
        end
    end

    // two input channels
    for (genvar g = 0; g < 2; g++) begin : g_ch
        tlink_chan #(.BUSY_W(BUSY_W)) u_ch (
            .clk_i      (clk_i),
            .rst_i      (rst_i),
            .cfg_i      (cfg_q[g]),
            .busy_cyc_i (busy_q[g]),
            .run_i      (run_w),
            .front_i    ({self_station_trigger_terminal_i[g], peak_done_i[g], peak_roi_i[g], peak_err_i[g]}),
            .oth_station_trigger_terminal_i (station_trigger_terminal_w[1-g]),
            .oth_whp_i  (whp_w[1-g]),
            .link_ev_i  (link_ev_w),
            .bp_ev_i    (bp_ev_w),
            .station_trigger_terminal_o     (station_trigger_terminal_w[g]),
            .whp_o      (whp_w[g]),
            .valid_o    (valid_w[g]),
            .busy_o     (busy_w[g])
        );
        // selected pulse type per destination
        assign link_drv_w[g] = (cfg_q[g].dst == TLINK_DST_LINK) &&
                               (cfg_q[g].send_whp ? whp_w[g] : station_trigger_terminal_w[g]);
        assign bp_drv_w[g]   = (cfg_q[g].dst == TLINK_DST_BP) &&
                               (cfg_q[g].send_whp ? whp_w[g] : station_trigger_terminal_w[g]);
    end

    // line drivers stretched to the merge time so peers see them
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lhold_q <= 4'h0;
            bhold_q <= 4'h0;
            link_line_o <= 1'b0;
            link_line_oe_o <= 1'b0;
            bp_line_o <= 1'b0;
            bp_line_oe_o <= 1'b0;
            run_o <= 1'b0;
            valid_o <= 2'b00;
            evt_q[0] <= 32'h0000_0000;
            evt_q[1] <= 32'h0000_0000;
        end else begin
            lhold_q <= (|link_drv_w) ? 4'(MERGE_CYC) : (lhold_q != 4'h0 ? lhold_q - 4'h1 : 4'h0);
            bhold_q <= (|bp_drv_w) ? 4'(MERGE_CYC) : (bhold_q != 4'h0 ? bhold_q - 4'h1 : 4'h0);
            link_line_o <= (|link_drv_w) || (lhold_q > 4'h1);
            link_line_oe_o <= (|link_drv_w) || (lhold_q > 4'h1);
            bp_line_o <= (|bp_drv_w) || (bhold_q > 4'h1);
            bp_line_oe_o <= (|bp_drv_w) || (bhold_q > 4'h1);
            run_o <= run_w;
            valid_o <= valid_w;
            evt_q[0] <= evt_q[0] + {31'h0, valid_w[0]};
            evt_q[1] <= evt_q[1] + {31'h0, valid_w[1]};
        end
    end

    chk_bp_start : assert property (@(posedge clk_i) disable iff (rst_i)
        (st_q == TLINK_ST_ARM) && bp_ev_w && !stop_w |=> run_w) else $error("armed start missed");
    chk_arm_hold : assert property (@(posedge clk_i) disable iff (rst_i)
        (st_q == TLINK_ST_ARM) && !bp_ev_w |=> !run_w) else $error("started without pulse");
    chk_norm_start : assert property (@(posedge clk_i) disable iff (rst_i)
        (st_q == TLINK_ST_IDLE) && start_w && !bpmode_w |=> run_w) else $error("normal start late");
    chk_src_reject : assert property (@(posedge clk_i) disable iff (rst_i)
        bpmode_w |-> cfg_q[0].src != TLINK_SRC_BP || $past(cfg_q[0].src) == TLINK_SRC_BP)
        else $error("backplane source accepted");
    chk_link_edge : assert property (@(posedge clk_i) disable iff (rst_i)
        link_ev_w |=> !link_ev_w) else $error("link event longer than a cycle");
endmodule

// >>> test/tlink_peer.sv
// far-side model: peer analyzers and the backplane trigger bus
`timescale 1ns/10ps
module tlink_peer #(
    parameter int HOLD = 3
) (
    input  wire logic clk_i,          // module clock
    input  wire logic rst_i,          // sync reset, active high
    input  wire logic req_link_i,     // send one link pulse
    input  wire logic req_bp_i,       // send one backplane pulse
    input  wire logic dut_link_i,     // device link drive
    input  wire logic dut_link_oe_i,  // device link enable
    input  wire logic dut_bp_i,       // device backplane drive
    input  wire logic dut_bp_oe_i,    // device backplane enable
    output logic      link_line_o,    // resolved link line
    output logic      bp_line_o       // resolved backplane line
);
    logic [3:0] lcnt_q;
    logic [3:0] bcnt_q;

    // link pulse stretcher, a peer holds its pulse for HOLD cycles
    always_ff @(posedge clk_i) begin
        if (rst_i || req_link_i) begin
            lcnt_q <= rst_i ? 4'h0 : 4'(HOLD);
        end else if (lcnt_q != 4'h0) begin
            lcnt_q <= lcnt_q - 4'h1;
        end
    end

    // backplane pulse stretcher, stands for the station start source
    always_ff @(posedge clk_i) begin
        if (rst_i || req_bp_i) begin
            bcnt_q <= rst_i ? 4'h0 : 4'(HOLD);
        end else if (bcnt_q != 4'h0) begin
            bcnt_q <= bcnt_q - 4'h1;
        end
    end

    // wired-or lines; released lines fall to the pull-down level, never hold
    assign link_line_o = (lcnt_q != 4'h0) | (dut_link_oe_i & dut_link_i);
    assign bp_line_o   = (bcnt_q != 4'h0) | (dut_bp_oe_i & dut_bp_i);
endmodule

// >>> test/tlink_top_tb.sv
// self-checking bench for the trigger link block
`timescale 1ns/10ps
`include "tlink_regs.svh"
module tlink_top_tb;
    import tlink_pkg::*;
    logic        clk_i = 1'b0, rst_i = 1'b1, we_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0;
    logic [7:0]  adr_i = 8'h00;
    logic [31:0] dat_i = 32'h0, dat_o;
    logic [3:0]  sel_i = 4'h0;
    logic [1:0]  self_station_trigger_terminal_i = 2'b00, peak_done_i = 2'b00, peak_roi_i = 2'b00, peak_err_i = 2'b00;
    logic        grp_bpmode_i = 1'b0, req_link = 1'b0, req_bp = 1'b0, l_q = 1'b0, b_q = 1'b0;
    logic        ack_o, err_o, link_line_o, link_line_oe_o, bp_line_o, bp_line_oe_o, run_o, link_line, bp_line;
    logic [1:0]  valid_o, rv, ev, vv;
    int          num_errors = 0, compares = 0, link_cnt = 0, bp_cnt = 0, exp_link = 0, exp_e0 = 0, exp_e1 = 0;
    logic [32:0] rd_q[$];
    logic [1:0]  val_q[$];

    tlink_top dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .we_i(we_i),
        .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o), .self_station_trigger_terminal_i(self_station_trigger_terminal_i),
        .peak_done_i(peak_done_i), .peak_roi_i(peak_roi_i), .peak_err_i(peak_err_i), .link_line_i(link_line),
        .bp_line_i(bp_line), .grp_bpmode_i(grp_bpmode_i), .link_line_o(link_line_o),
        .link_line_oe_o(link_line_oe_o), .bp_line_o(bp_line_o), .bp_line_oe_o(bp_line_oe_o), .run_o(run_o),
        .valid_o(valid_o));
    tlink_peer peer (.clk_i(clk_i), .rst_i(rst_i), .req_link_i(req_link), .req_bp_i(req_bp),
        .dut_link_i(link_line_o), .dut_link_oe_i(link_line_oe_o), .dut_bp_i(bp_line_o),
        .dut_bp_oe_i(bp_line_oe_o), .link_line_o(link_line), .bp_line_o(bp_line));

    // 10 MHz clock
    always #50 clk_i = ~clk_i;

    task automatic chk(string name, logic [32:0] exp, logic [32:0] got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task give_verdict;
        if (num_errors == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // classic single cycle, held until ack or err is sampled high
    task automatic wb(logic [7:0] a, logic w, logic [31:0] d);
        int n;
        n = 0;
        adr_i <= a;
        we_i <= w;
        dat_i <= d;
        sel_i <= 4'hf;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 50);
        if (n >= 50) begin
            num_errors++;
            give_verdict();
        end
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rd(logic [7:0] a, logic [32:0] exp);
        rd_q.push_back(exp);
        wb(a, 1'b0, 32'h0);
    endtask

    task automatic tick(int n);
        repeat (n) @(posedge clk_i);
    endtask

    // config word: busy, error check, region, peak mode, window hit, destination, source
    function automatic logic [31:0] cfg(tlink_src_e s, tlink_dst_e d, logic wh, logic [15:0] bz);
        return {bz, 7'h00, 1'b1, 1'b1, 1'b1, wh, d, s};
    endfunction

    // result watcher: oldest note against each read answer, link and backplane pulses counted
    always @(posedge clk_i) begin
        l_q <= link_line_oe_o & link_line_o;
        b_q <= bp_line_oe_o & bp_line_o;
        if ((link_line_oe_o & link_line_o) === 1'b1 && l_q !== 1'b1) link_cnt++;
        if ((bp_line_oe_o & bp_line_o) === 1'b1 && b_q !== 1'b1) bp_cnt++;
        if ((ack_o === 1'b1 || err_o === 1'b1) && we_i === 1'b0)
            chk("read", rd_q.size() > 0 ? rd_q.pop_front() : 33'h1_ffff_ffff, {err_o, dat_o});
        if (valid_o !== 2'b00)
            chk("valid", val_q.size() > 0 ? val_q.pop_front() : 2'b00, valid_o);
    end

    // hang guard, the tests need under 3000 cycles
    initial begin
        tick(20000);
        num_errors++;
        give_verdict();
    end

    initial begin
        void'($urandom(32'h9b1dfd71));
        tick(16);
        rst_i <= 1'b0;
        tick(1);
        rd(`TLINK_OFF_CTRL, 33'h0);
        rd(`TLINK_OFF_IN0, 33'h0);
        rd(`TLINK_OFF_STAT, 33'h0);
        rd(`TLINK_OFF_EVT0, 33'h0);
        rd(8'h20, {1'b1, 32'h0});
        // slave window two cycles shorter than the master's
        wb(`TLINK_OFF_IN1, 1'b1, cfg(TLINK_SRC_LINK, TLINK_DST_NONE, 1'b0, 16'd18));
        wb(`TLINK_OFF_CTRL, 1'b1, 32'h1);
        rd(`TLINK_OFF_STAT, 33'h1);
        chk("run", 33'h1, run_o);
        // trigger then window hit driven onto the link, looped back into input 1
        for (int w = 0; w < 2; w++) begin
            wb(`TLINK_OFF_IN0, 1'b1, cfg(TLINK_SRC_SELF, TLINK_DST_LINK, w[0], 16'd20));
            rd(`TLINK_OFF_IN0, {1'b0, cfg(TLINK_SRC_SELF, TLINK_DST_LINK, w[0], 16'd20)});
            for (int i = 0; i < 4; i++) begin
                rv = 2'($urandom);
                ev = 2'($urandom);
                vv = (rv & ~ev) & (w == 1 ? 2'b01 : 2'b11);
                self_station_trigger_terminal_i <= 2'b01;
                tick(1);
                self_station_trigger_terminal_i <= 2'b00;
                tick(5);
                self_station_trigger_terminal_i <= 2'b01;
                tick(1);
                self_station_trigger_terminal_i <= 2'b00;
                tick(4);
                peak_roi_i <= rv;
                peak_err_i <= ev;
                peak_done_i <= (w == 1) ? 2'b01 : 2'b11;
                if (vv != 2'b00) val_q.push_back(vv);
                exp_e0 += int'(vv[0]);
                exp_e1 += int'(vv[1]);
                tick(1);
                peak_done_i <= 2'b00;
                exp_link += (w == 1) ? int'(vv[0]) : 1;
                tick(30);
            end
        end
        chk("link pulses", exp_link, link_cnt);
        wb(`TLINK_OFF_IN0, 1'b1, cfg(TLINK_SRC_SELF, TLINK_DST_BP, 1'b0, 16'd20));
        self_station_trigger_terminal_i <= 2'b01;
        tick(1);
        self_station_trigger_terminal_i <= 2'b00;
        tick(30);
        chk("bp pulses", 33'h1, bp_cnt);
        // a peer alone on the link triggers input 1
        req_link <= 1'b1;
        tick(1);
        req_link <= 1'b0;
        tick(8);
        peak_roi_i <= 2'b10;
        peak_err_i <= 2'b00;
        peak_done_i <= 2'b10;
        val_q.push_back(2'b10);
        exp_e1 += 1;
        tick(1);
        peak_done_i <= 2'b00;
        tick(30);
        wb(`TLINK_OFF_CTRL, 1'b1, 32'h2);
        rd(`TLINK_OFF_STAT, 33'h0);
        wb(`TLINK_OFF_CTRL, 1'b1, 32'h4);
        wb(`TLINK_OFF_IN0, 1'b1, cfg(TLINK_SRC_BP, TLINK_DST_NONE, 1'b0, 16'd20));
        rd(`TLINK_OFF_IN0, {1'b0, cfg(TLINK_SRC_SELF, TLINK_DST_BP, 1'b0, 16'd20)});
        rd(`TLINK_OFF_STAT, 33'h4);
        wb(`TLINK_OFF_CTRL, 1'b1, 32'h5);
        rd(`TLINK_OFF_STAT, 33'h6);
        chk("run", 33'h0, run_o);
        req_bp <= 1'b1;
        tick(1);
        req_bp <= 1'b0;
        tick(8);
        chk("run", 33'h1, run_o);
        // linked group mode overrides the module's own setting
        wb(`TLINK_OFF_CTRL, 1'b1, 32'h2);
        grp_bpmode_i <= 1'b1;
        wb(`TLINK_OFF_CTRL, 1'b1, 32'h8);
        wb(`TLINK_OFF_IN0, 1'b1, cfg(TLINK_SRC_BP, TLINK_DST_NONE, 1'b0, 16'd20));
        rd(`TLINK_OFF_IN0, {1'b0, cfg(TLINK_SRC_SELF, TLINK_DST_BP, 1'b0, 16'd20)});
        grp_bpmode_i <= 1'b0;
        wb(`TLINK_OFF_IN0, 1'b1, cfg(TLINK_SRC_BP, TLINK_DST_NONE, 1'b0, 16'd20));
        rd(`TLINK_OFF_IN0, {1'b0, cfg(TLINK_SRC_BP, TLINK_DST_NONE, 1'b0, 16'd20)});
        rd(`TLINK_OFF_STAT, 33'h0);
        // kept-event counters match the events the bench expected to survive
        rd(`TLINK_OFF_EVT0, 33'(exp_e0));
        rd(`TLINK_OFF_EVT1, 33'(exp_e1));
        tick(4);
        chk("pending", 33'h0, rd_q.size() + val_q.size());
        give_verdict();
    end
endmodule
